//--- chs_params.svh
// Timing counts and widths for the card host signal control block
`ifndef CHS_PARAMS_SVH
`define CHS_PARAMS_SVH

// ----------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------
`define CHS_CLK_PERIOD_NS 100

// ----------------------------------------------------------------------
// Busy times (least times, rounded up to whole cycles)
// ----------------------------------------------------------------------
`define CHS_PWRUP_BUSY_NS 2000
`define CHS_PWRUP_BUSY_CYC \
   ((`CHS_PWRUP_BUSY_NS + `CHS_CLK_PERIOD_NS - 1) / `CHS_CLK_PERIOD_NS)
`define CHS_RST_BUSY_NS 1000
`define CHS_RST_BUSY_CYC \
   ((`CHS_RST_BUSY_NS + `CHS_CLK_PERIOD_NS - 1) / `CHS_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Pulse-mode interrupt width (least time)
// ----------------------------------------------------------------------
`define CHS_IRQ_PULSE_NS 500
`define CHS_IRQ_PULSE_CYC \
   ((`CHS_IRQ_PULSE_NS + `CHS_CLK_PERIOD_NS - 1) / `CHS_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Counter width and synchroniser width
// ----------------------------------------------------------------------
`define CHS_CNT_W 8
`define CHS_SYNC_W 5

`endif

//--- chs_pkg.sv
// Types shared by the card host signal control block
package chs_pkg;

   // ----------------------------------------------------------------------
   // Host pins that need synchronising, in one bundle
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic oe_n;      // Read strobe, also IDE mode select
      logic reg_n;     // Attribute select, low = attribute memory
      logic reset_pin; // Card reset pin, polarity depends on mode
      logic dmack_n;   // DMA acknowledge, active low
      logic stop;      // Ultra DMA burst stop
   } chs_pins_t;

   // ----------------------------------------------------------------------
   // Decoded read strobes towards the card core
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic common_rd; // Common memory read, memory mode only
      logic attrib_rd; // Card information / configuration read
   } chs_read_t;

   // ----------------------------------------------------------------------
   // Interface modes
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      CHS_MODE_MEM = 3'h1,
      CHS_MODE_IO  = 3'h2,
      CHS_MODE_IDE = 3'h4
   } chs_mode_t;

   // ----------------------------------------------------------------------
   // Power-up / reset sequencer states
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      CHS_RS_PWRUP = 3'h1,
      CHS_RS_BUSY  = 3'h2,
      CHS_RS_RUN   = 3'h4
   } chs_rst_state_t;

   // ----------------------------------------------------------------------
   // DMA handshake states
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      CHS_DS_IDLE = 4'h1,
      CHS_DS_REQ  = 4'h2,
      CHS_DS_XFER = 4'h4,
      CHS_DS_TERM = 4'h8
   } chs_dma_state_t;

endpackage

//--- chs_sync.sv
// Two-stage synchroniser for a bundle of asynchronous host pins
`timescale 1ns/1ps
module chs_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   // ----------------------------------------------------------------------
   // Stages
   // ----------------------------------------------------------------------
   // First stage feeds only the second stage
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end else begin
         meta_ff <= i_async;
         sync_ff <= meta_ff;
      end
   end

   assign o_sync = sync_ff;

endmodule

//--- chs_ctrl.sv
// Host control signal logic of a removable flash card
//
// Overview of operation
// [R1]: In IDE Ultra DMA, STOP from the host ends the burst in progress.
// [R2]: The host makes the read strobe; memory mode uses it for data too.
// [R3]: In I/O mode the read strobe only reads the attribute space.
// [R4]: Holding the IDE mode select input low selects True IDE mode.
// [R5]: In memory mode ready is high when idle and low while busy.
// [R6]: Ready stays low until the power-up or reset sequence finishes.
// [R7]: The host makes no access while ready shows busy.
// [R8]: A reset pin held active since power-up is ignored, not a hang.
// [R9]: In I/O mode the interrupt line pulses low or holds low by mode.
// [R10]: In IDE mode the interrupt is an active high output.
// [R11]: Attribute select high picks common memory, low attribute memory.
// [R12]: In I/O cycles the host also holds attribute select low.
// [R13]: The host answers the DMA request with DMA acknowledge.
// [R14]: DMA acknowledge is ignored while no DMA operation is active.
// [R15]: A host without DMA holds DMA acknowledge high.
// [R16]: Host strobes and selects are synchronised before use.
`include "chs_params.svh"
`timescale 1ns/1ps
module chs_ctrl #(
   parameter int CNT_W = `CHS_CNT_W,
   parameter logic [CNT_W-1:0] PWRUP_CYC = CNT_W'(`CHS_PWRUP_BUSY_CYC),
   parameter logic [CNT_W-1:0] RST_CYC = CNT_W'(`CHS_RST_BUSY_CYC),
   parameter logic [CNT_W-1:0] IRQ_CYC = CNT_W'(`CHS_IRQ_PULSE_CYC)
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_oe_n,
   input wire logic i_reg_n,
   input wire logic i_reset_pin,
   input wire logic i_dmack_n,
   input wire logic i_stop,
   input wire logic i_core_busy,
   input wire logic i_io_configured,
   input wire logic i_irq_level_mode,
   input wire logic i_irq,
   input wire logic i_dma_want,
   input wire logic i_udma_en,
   input wire logic i_dma_done,
   output logic o_ready_irq,
   output logic o_dmarq,
   output chs_pkg::chs_read_t o_read,
   output logic o_dma_ack,
   output logic o_burst_stop,
   output logic o_card_reset,
   output chs_pkg::chs_mode_t o_mode
);

   // ----------------------------------------------------------------------
   // Synchronised host pins
   // ----------------------------------------------------------------------
   chs_pkg::chs_pins_t pins_raw;
   chs_pkg::chs_pins_t pins_s;
   logic [`CHS_SYNC_W-1:0] pins_vec;

   // Idle pin levels: strobes high, reset pin low, stop low
   localparam logic [`CHS_SYNC_W-1:0] PINS_IDLE = 5'h1A;

   assign pins_raw.oe_n = i_oe_n;
   assign pins_raw.reg_n = i_reg_n;
   assign pins_raw.reset_pin = i_reset_pin;
   assign pins_raw.dmack_n = i_dmack_n;
   assign pins_raw.stop = i_stop;

   // Strobes are asynchronous to the card clock [R16]
   chs_sync #(
      .W(`CHS_SYNC_W),
      .RST_VAL(PINS_IDLE)
   ) u_sync (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_async(pins_raw),
      .o_sync(pins_vec)
   );

   assign pins_s = chs_pkg::chs_pins_t'(pins_vec);

   // ----------------------------------------------------------------------
   // Edge history of synchronised strobes and of the core interrupt request
   // ----------------------------------------------------------------------
   logic oe_n_d_ff;
   logic stop_d_ff;
   logic irq_d_ff;

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         oe_n_d_ff <= 1'h1;
         stop_d_ff <= 1'h0;
         irq_d_ff <= 1'h0;
      end else begin
         oe_n_d_ff <= pins_s.oe_n;
         stop_d_ff <= pins_s.stop;
         irq_d_ff <= i_irq;
      end
   end

   logic oe_fall;
   logic stop_rise;
   logic irq_rise;

   assign oe_fall = oe_n_d_ff & ~pins_s.oe_n;
   assign stop_rise = ~stop_d_ff & pins_s.stop;
   assign irq_rise = ~irq_d_ff & i_irq;

   // ----------------------------------------------------------------------
   // Power-up / reset sequencer
   // ----------------------------------------------------------------------
   chs_pkg::chs_rst_state_t rst_st_ff;
   chs_pkg::chs_rst_state_t nxt_rst_st;
   logic [CNT_W-1:0] busy_cnt_ff;
   logic ide_ff;
   logic rst_idle_seen_ff;
   logic rst_act;
   logic rst_act_d_ff;
   logic rst_start;
   logic ready_phase;

   // Card reset pin is high active, except active low in IDE mode
   assign rst_act = ide_ff ? ~pins_s.reset_pin : pins_s.reset_pin;

   // Only a reset that starts after the pin was once inactive counts, so a
   // pin left open or held active from power-up cannot hang the card [R8]
   assign rst_start = rst_idle_seen_ff & rst_act & ~rst_act_d_ff;

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         rst_idle_seen_ff <= 1'h0;
         rst_act_d_ff <= 1'h0;
      end else begin
         rst_act_d_ff <= rst_act;
         if (rst_st_ff == chs_pkg::CHS_RS_RUN && !rst_act) begin
            rst_idle_seen_ff <= 1'h1; // [R8]
         end
      end
   end

   // Sequencer next state
   always_comb begin
      nxt_rst_st = rst_st_ff;
      case (rst_st_ff)
         chs_pkg::CHS_RS_PWRUP: begin
            if (busy_cnt_ff == '0) begin
               nxt_rst_st = chs_pkg::CHS_RS_RUN;
            end
         end
         chs_pkg::CHS_RS_BUSY: begin
            if (busy_cnt_ff == '0 && !rst_act) begin
               nxt_rst_st = chs_pkg::CHS_RS_RUN;
            end
         end
         chs_pkg::CHS_RS_RUN: begin
            if (rst_start) begin
               nxt_rst_st = chs_pkg::CHS_RS_BUSY;
            end
         end
         default: begin
            nxt_rst_st = chs_pkg::CHS_RS_PWRUP;
         end
      endcase
   end

   // Busy countdown; reloaded on entry to either busy state [R6]
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         rst_st_ff <= chs_pkg::CHS_RS_PWRUP;
         busy_cnt_ff <= PWRUP_CYC;
      end else begin
         rst_st_ff <= nxt_rst_st;
         if (rst_start) begin
            busy_cnt_ff <= RST_CYC;
         end else if (busy_cnt_ff != '0) begin
            busy_cnt_ff <= busy_cnt_ff - CNT_W'(1);
         end
      end
   end

   assign ready_phase = (rst_st_ff == chs_pkg::CHS_RS_RUN);

   // Mode select is caught while busy, so it is stable once running [R4]
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         ide_ff <= 1'h0;
      end else if (!ready_phase) begin
         ide_ff <= ~pins_s.oe_n; // Select input grounded means IDE [R4]
      end
   end

   // Core reset pulse, one cycle, on each accepted reset
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_card_reset <= 1'h0;
      end else begin
         o_card_reset <= rst_start;
      end
   end

   // ----------------------------------------------------------------------
   // Mode
   // ----------------------------------------------------------------------
   chs_pkg::chs_mode_t mode;

   always_comb begin
      if (ide_ff) begin
         mode = chs_pkg::CHS_MODE_IDE;
      end else if (i_io_configured && ready_phase) begin
         mode = chs_pkg::CHS_MODE_IO;
      end else begin
         mode = chs_pkg::CHS_MODE_MEM;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_mode <= chs_pkg::CHS_MODE_MEM;
      end else begin
         o_mode <= mode;
      end
   end

   // ----------------------------------------------------------------------
   // Read strobe decode
   // ----------------------------------------------------------------------
   // Strobe use by mode; in IDE mode the pin is the mode select instead
   function automatic chs_pkg::chs_read_t read_decode(
      input chs_pkg::chs_mode_t m,
      input logic fall,
      input logic reg_n
   );
      chs_pkg::chs_read_t r;
      r = '0;
      if (m == chs_pkg::CHS_MODE_MEM) begin
         r.common_rd = fall & reg_n;  // [R2] [R11]
         r.attrib_rd = fall & ~reg_n; // [R11]
      end else if (m == chs_pkg::CHS_MODE_IO) begin
         r.attrib_rd = fall & ~reg_n; // [R3] [R12]
      end
      return r;
   endfunction

   // Reads during the busy phase are dropped; host must not access [R7]
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_read <= '0;
      end else if (ready_phase) begin
         o_read <= read_decode(mode, oe_fall, pins_s.reg_n);
      end else begin
         o_read <= '0;
      end
   end

   // ----------------------------------------------------------------------
   // Interrupt request, pulse or level
   // ----------------------------------------------------------------------
   logic [CNT_W-1:0] irq_cnt_ff;

   // Pulse mode holds the line low for a fixed width per rising request
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         irq_cnt_ff <= '0;
      end else if (mode != chs_pkg::CHS_MODE_IO || i_irq_level_mode) begin
         irq_cnt_ff <= '0;
      end else if (irq_rise) begin
         irq_cnt_ff <= IRQ_CYC; // [R9]
      end else if (irq_cnt_ff != '0) begin
         irq_cnt_ff <= irq_cnt_ff - CNT_W'(1);
      end
   end

   logic interrupt_request_n;
   logic nxt_pin;

   assign interrupt_request_n = i_irq_level_mode ? ~i_irq :
                                (irq_cnt_ff == '0); // [R9]

   // Shared pin: ready, interrupt request low, or IDE interrupt high
   always_comb begin
      case (mode)
         chs_pkg::CHS_MODE_IDE: nxt_pin = ready_phase & i_irq; // [R10]
         chs_pkg::CHS_MODE_IO: nxt_pin = interrupt_request_n; // [R9]
         // Drop ready on the very edge that takes a card reset, so the pin
         // never shows ready beside the reset pulse
         default: begin
            nxt_pin = ready_phase & ~rst_start & ~i_core_busy; // [R5] [R6]
         end
      endcase
   end

   // Registered pin; low from reset until the sequencer is running [R6]
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_ready_irq <= 1'h0;
      end else begin
         o_ready_irq <= nxt_pin;
      end
   end

   // ----------------------------------------------------------------------
   // DMA handshake
   // ----------------------------------------------------------------------
   chs_pkg::chs_dma_state_t dma_st_ff;
   chs_pkg::chs_dma_state_t nxt_dma_st;
   logic dma_on;
   logic dmack;

   assign dma_on = ready_phase & (mode == chs_pkg::CHS_MODE_IDE);
   // Acknowledge only means anything while the handshake is not idle; a floating
   // or tied line is ignored otherwise [R14] [R15]
   assign dmack = ~pins_s.dmack_n & (dma_st_ff != chs_pkg::CHS_DS_IDLE);

   always_comb begin
      nxt_dma_st = dma_st_ff;
      case (dma_st_ff)
         chs_pkg::CHS_DS_IDLE: begin
            if (dma_on && i_dma_want) begin
               nxt_dma_st = chs_pkg::CHS_DS_REQ;
            end
         end
         chs_pkg::CHS_DS_REQ: begin
            if (!dma_on) begin
               nxt_dma_st = chs_pkg::CHS_DS_IDLE;
            end else if (dmack) begin
               nxt_dma_st = chs_pkg::CHS_DS_XFER; // [R13]
            end
         end
         chs_pkg::CHS_DS_XFER: begin
            if (!dma_on || i_dma_done) begin
               nxt_dma_st = chs_pkg::CHS_DS_TERM;
            end else if (i_udma_en && stop_rise) begin
               nxt_dma_st = chs_pkg::CHS_DS_TERM; // [R1]
            end
         end
         chs_pkg::CHS_DS_TERM: begin
            if (!dmack) begin
               nxt_dma_st = chs_pkg::CHS_DS_IDLE;
            end
         end
         default: begin
            nxt_dma_st = chs_pkg::CHS_DS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         dma_st_ff <= chs_pkg::CHS_DS_IDLE;
      end else begin
         dma_st_ff <= nxt_dma_st;
      end
   end

   // Request held from REQ through XFER, dropped on termination
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_dmarq <= 1'h0;
         o_dma_ack <= 1'h0;
         o_burst_stop <= 1'h0;
      end else begin
         o_dmarq <= (nxt_dma_st == chs_pkg::CHS_DS_REQ) ||
                    (nxt_dma_st == chs_pkg::CHS_DS_XFER); // [R13]
         o_dma_ack <= dmack & (nxt_dma_st == chs_pkg::CHS_DS_XFER);
         // One pulse tells the core that the host cut the burst short
         o_burst_stop <= (dma_st_ff == chs_pkg::CHS_DS_XFER) && dma_on &&
                         !i_dma_done && i_udma_en && stop_rise; // [R1]
      end
   end

endmodule

//--- chs_ctrl_sva.sv
// Assertion checker for the card host signal control block
`timescale 1ns/1ps
module chs_ctrl_sva #(
   parameter int CNT_W = 8,
   parameter logic [CNT_W-1:0] PWRUP_CYC = '0
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_core_busy,
   input wire logic i_irq,
   input wire logic i_irq_level_mode,
   input wire logic i_udma_en,
   input wire logic o_ready_irq,
   input wire logic o_dmarq,
   input wire chs_pkg::chs_read_t o_read,
   input wire logic o_dma_ack,
   input wire logic o_burst_stop,
   input wire logic o_card_reset,
   input wire chs_pkg::chs_mode_t o_mode
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);

   // Cycles since reset release, saturating so it never wraps
   logic [CNT_W-1:0] up_cnt_ff;
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         up_cnt_ff <= '0;
      end else if (up_cnt_ff != '1) begin
         up_cnt_ff <= up_cnt_ff + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Ready and reset
   // ---------------------------------------------------------------
   property p_ready_pwrup;
      o_ready_irq |-> up_cnt_ff >= PWRUP_CYC;
   endproperty
   a_ready_pwrup: assert property (p_ready_pwrup)
      else $error("ready high inside power-up busy time");
   property p_ready_busy;
      o_mode == chs_pkg::CHS_MODE_MEM && o_ready_irq |-> !$past(i_core_busy);
   endproperty
   a_ready_busy: assert property (p_ready_busy)
      else $error("ready high while core busy");
   property p_crst_busy;
      o_card_reset && o_mode == chs_pkg::CHS_MODE_MEM |-> !o_ready_irq [*3];
   endproperty
   a_crst_busy: assert property (p_crst_busy)
      else $error("ready not held low after card reset");

   // ---------------------------------------------------------------
   // Read strobes
   // ---------------------------------------------------------------
   property p_rd_common;
      o_read.common_rd |-> o_mode == chs_pkg::CHS_MODE_MEM && !o_read.attrib_rd;
   endproperty
   a_rd_common: assert property (p_rd_common)
      else $error("common read outside memory mode");
   property p_rd_pulse;
      o_read != '0 |=> o_read == '0;
   endproperty
   a_rd_pulse: assert property (p_rd_pulse)
      else $error("read pulse longer than one cycle");

   // ---------------------------------------------------------------
   // Interrupts; pulse width assumes IRQ_CYC of 5
   // ---------------------------------------------------------------
   property p_irq_pulse;
      o_mode == chs_pkg::CHS_MODE_IO && !i_irq_level_mode && $rose(i_irq)
         |-> ##[1:2] !o_ready_irq [*5];
   endproperty
   a_irq_pulse: assert property (p_irq_pulse)
      else $error("pulse interrupt too short");
   property p_irq_level;
      o_mode == chs_pkg::CHS_MODE_IO && $past(i_irq_level_mode)
         && $past(i_irq) && $past(i_irq, 2) |-> !o_ready_irq;
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("level interrupt not held low");
   property p_irq_ide;
      o_mode == chs_pkg::CHS_MODE_IDE && o_ready_irq |-> $past(i_irq);
   endproperty
   a_irq_ide: assert property (p_irq_ide)
      else $error("IDE interrupt without request");

   // ---------------------------------------------------------------
   // DMA handshake
   // ---------------------------------------------------------------
   property p_ack_req;
      $rose(o_dma_ack) |-> $past(o_dmarq) && o_mode == chs_pkg::CHS_MODE_IDE;
   endproperty
   a_ack_req: assert property (p_ack_req)
      else $error("acknowledge taken without request");
   property p_stop;
      o_burst_stop |-> !o_dmarq && !o_dma_ack && $past(o_dma_ack)
         && $past(i_udma_en);
   endproperty
   a_stop: assert property (p_stop)
      else $error("burst stop outside an active burst");
endmodule

bind chs_ctrl chs_ctrl_sva #(
   .CNT_W(CNT_W),
   .PWRUP_CYC(PWRUP_CYC)
) u_chs_sva (
   .i_ref_clk(i_ref_clk),
   .i_rst_n(i_rst_n),
   .i_core_busy(i_core_busy),
   .i_irq(i_irq),
   .i_irq_level_mode(i_irq_level_mode),
   .i_udma_en(i_udma_en),
   .o_ready_irq(o_ready_irq),
   .o_dmarq(o_dmarq),
   .o_read(o_read),
   .o_dma_ack(o_dma_ack),
   .o_burst_stop(o_burst_stop),
   .o_card_reset(o_card_reset),
   .o_mode(o_mode)
);

//--- chs_host_model.sv
// Host bus controller model driving the card control pins
`timescale 1ns/1ps
module chs_host_model (
   input wire logic i_ref_clk,
   input wire logic i_dmarq,
   output chs_pkg::chs_pins_t o_pins
);
   // Idle host: strobe high, no reset, acknowledge held high
   initial begin
      o_pins = 5'h1A;
   end

   // Bit map: 4 strobe, 3 attribute select, 2 reset, 1 ack, 0 stop
   task automatic set_line(input int idx, input logic v);
      @(posedge i_ref_clk);
      o_pins[idx] <= v;
   endtask

   // Select settles a cycle ahead of the strobe and outlasts it
   task automatic read(input logic reg_n);
      set_line(3, reg_n);
      set_line(4, 1'b0);
      repeat (5) @(posedge i_ref_clk);
      o_pins.oe_n <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      o_pins.reg_n <= 1'b1;
   endtask

   // Acknowledge once a request is seen or 20 cycles pass, then stop the burst
   task automatic burst(output logic ok);
      int n;
      n = 0;
      while (i_dmarq !== 1'b1 && n < 20) begin
         @(posedge i_ref_clk);
         n++;
      end
      ok = i_dmarq;
      set_line(1, 1'b0);
      repeat (8) @(posedge i_ref_clk);
      o_pins.stop <= 1'b1;
      repeat (8) @(posedge i_ref_clk);
      o_pins.stop <= 1'b0;
      o_pins.dmack_n <= 1'b1;
   endtask
endmodule

//--- tb_card_host_signal_control.sv
// Self-checking testbench for the card host signal control block
`timescale 1ns/1ps
module tb_card_host_signal_control;
   logic i_ref_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic busy = 1'b0, io_cfg = 1'b0, lvl = 1'b0, irq = 1'b0;
   logic want = 1'b0, udma = 1'b0, done = 1'b0, ok;
   logic ready, dmarq, dack, bstop, crst;
   chs_pkg::chs_read_t rd;
   chs_pkg::chs_mode_t mode;
   chs_pkg::chs_pins_t pins;
   logic [1:0] s_rd;
   logic s_crst, s_stop, s_ack, s_lo, s_hi;
   int num_errors = 0;
   int n_checks = 0;

   // 10 MHz reference clock
   always #50 i_ref_clk = ~i_ref_clk;

   chs_host_model host_u (
      .i_ref_clk(i_ref_clk),
      .i_dmarq(dmarq),
      .o_pins(pins)
   );

   chs_ctrl #(
      .PWRUP_CYC(8'h14),
      .RST_CYC(8'h0A),
      .IRQ_CYC(8'h05)
   ) dut_u (
      .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_oe_n(pins.oe_n),
      .i_reg_n(pins.reg_n), .i_reset_pin(pins.reset_pin),
      .i_dmack_n(pins.dmack_n), .i_stop(pins.stop), .i_core_busy(busy),
      .i_io_configured(io_cfg), .i_irq_level_mode(lvl), .i_irq(irq),
      .i_dma_want(want), .i_udma_en(udma), .i_dma_done(done),
      .o_ready_irq(ready), .o_dmarq(dmarq), .o_read(rd),
      .o_dma_ack(dack), .o_burst_stop(bstop), .o_card_reset(crst),
      .o_mode(mode)
   );

   // ---------------------------------------------------------------
   // Shared helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
      end
   endtask

   // Collect every pulse over n cycles, since pulses last one cycle
   task automatic run(input int n);
      {s_rd, s_crst, s_stop, s_ack, s_lo, s_hi} = 7'h00;
      repeat (n) begin
         @(negedge i_ref_clk);
         s_rd = s_rd | rd;
         {s_crst, s_stop, s_ack} = {s_crst, s_stop, s_ack} | {crst, bstop, dack};
         s_lo = s_lo | !ready;
         s_hi = s_hi | ready;
      end
   endtask

   task automatic wait_ready(input int lim);
      int n;
      n = 0;
      while (ready !== 1'b1 && n < lim) begin
         @(negedge i_ref_clk);
         n++;
      end
      chk(ready, 1'b1);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_powerup();
      host_u.set_line(2, 1'b1);
      repeat (11) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      run(15);
      chk(s_hi, 1'b0);
      wait_ready(20);
      chk(s_crst, 1'b0);
      chk(mode, chs_pkg::CHS_MODE_MEM);
      host_u.set_line(2, 1'b0);
      run(8);
      chk(s_crst, 1'b0);
   endtask

   task automatic t_read(input logic reg_n, input logic [1:0] exp);
      fork
         host_u.read(reg_n);
         run(14);
      join
      chk(s_rd, exp);
   endtask

   task automatic t_busy();
      @(posedge i_ref_clk);
      busy <= 1'b1;
      run(4);
      chk(ready, 1'b0);
      @(posedge i_ref_clk);
      busy <= 1'b0;
      run(3);
      chk(ready, 1'b1);
   endtask

   task automatic t_card_reset();
      host_u.set_line(2, 1'b1);
      run(8);
      chk(s_crst, 1'b1);
      chk(ready, 1'b0);
      host_u.set_line(2, 1'b0);
      wait_ready(20);
   endtask

   // Each edge of the request waits a few cycles, for the pin delay
   task automatic t_irq(input logic l, input logic [2:0] e);
      @(posedge i_ref_clk);
      lvl <= l;
      irq <= 1'b1;
      run(3);
      chk(ready, e[2]);
      run(8);
      chk(ready, e[1]);
      @(posedge i_ref_clk);
      irq <= 1'b0;
      run(3);
      chk(ready, e[0]);
   endtask

   task automatic t_io();
      @(posedge i_ref_clk);
      io_cfg <= 1'b1;
      run(3);
      chk(mode, chs_pkg::CHS_MODE_IO);
      t_read(1'b1, 2'h0);
      t_read(1'b0, 2'h1);
      t_irq(1'b1, 3'h1);
      t_irq(1'b0, 3'h3);
   endtask

   task automatic t_ide();
      @(posedge i_ref_clk);
      io_cfg <= 1'b0;
      i_rst_n <= 1'b0;
      host_u.set_line(4, 1'b0);
      host_u.set_line(2, 1'b1);
      repeat (12) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      run(20);
      host_u.set_line(4, 1'b1);
      run(4);
      chk(mode, chs_pkg::CHS_MODE_IDE);
      t_irq(1'b0, 3'h6);
      host_u.set_line(1, 1'b0);
      run(8);
      chk(s_ack, 1'b0);
      host_u.set_line(1, 1'b1);
      // Let the released acknowledge clear the synchroniser first
      run(4);
      @(posedge i_ref_clk);
      udma <= 1'b1;
      want <= 1'b1;
      fork
         host_u.burst(ok);
         run(30);
         begin
            repeat (3) @(posedge i_ref_clk);
            want <= 1'b0;
         end
      join
      chk(ok, 1'b1);
      chk(s_ack, 1'b1);
      chk(s_stop, 1'b1);
      chk(dmarq, 1'b0);
   endtask

   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Watchdog: the sequence needs well under a thousand cycles
   initial begin
      #400000;
      num_errors++;
      report_and_stop();
   end

   initial begin
      t_powerup();
      t_read(1'b1, 2'h2);
      t_read(1'b0, 2'h1);
      t_busy();
      t_card_reset();
      t_io();
      t_ide();
      report_and_stop();
   end
endmodule
